/* shared/mpwm_defines.svh */
`ifndef MPWM_DEFINES_SVH
`define MPWM_DEFINES_SVH

// Register indexes on the plain register port.
`define MPWM_ADDR_TBCON 3'h0
`define MPWM_ADDR_COUNT 3'h1
`define MPWM_ADDR_PERIOD 3'h2
`define MPWM_ADDR_SECMP 3'h3
`define MPWM_ADDR_PAIRCFG 3'h4
`define MPWM_ADDR_STATUS 3'h5

// Time base control field positions.
`define MPWM_TB_ON_BIT 15
`define MPWM_TB_IDLE_BIT 13
`define MPWM_TB_POST_HI 7
`define MPWM_TB_POST_LO 4
`define MPWM_TB_PRE_HI 3
`define MPWM_TB_PRE_LO 2
`define MPWM_TB_MODE_HI 1
`define MPWM_TB_MODE_LO 0

// Count, period and compare fields.
`define MPWM_DIR_BIT 15
`define MPWM_VAL_HI 14

// Pair configuration field positions.
`define MPWM_PMOD_LO 8
`define MPWM_PENH_LO 4
`define MPWM_PENL_LO 0

// Prescale terminal counts, one less than the division ratio in instruction cycles.
`define MPWM_PRE_DIV1 7'h00
`define MPWM_PRE_DIV4 7'h03
`define MPWM_PRE_DIV16 7'h0f
`define MPWM_PRE_DIV64 7'h3f

`endif

/* shared/mpwm_pkg.sv */
package mpwm_pkg;
  // Time base count modes.
  typedef enum logic [1:0] {
    MPWM_MODE_FREE = 2'h0,
    MPWM_MODE_SINGLE = 2'h1,
    MPWM_MODE_UPDN = 2'h2,
    MPWM_MODE_UPDN_DBL = 2'h3
  } mpwm_mode_t;
endpackage

/* verilog/mpwm_pair_out.sv */
`timescale 1ns/1ns
`include "mpwm_defines.svh"

// Maps the duty generator levels onto high/low pin pairs.
module mpwm_pair_out
  import mpwm_pkg::*;
#(
  parameter int NPAIR = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [NPAIR-1:0] duty_level,
  input wire logic [NPAIR-1:0] low_level,
  input wire logic [NPAIR-1:0] indep_sel,
  input wire logic [NPAIR-1:0] high_en,
  input wire logic [NPAIR-1:0] low_en,
  output logic [NPAIR-1:0] high_side_output,
  output logic [NPAIR-1:0] low_side_output,
  output logic [NPAIR-1:0] high_side_oe,
  output logic [NPAIR-1:0] low_side_oe
);

  // Registered pins; complementary pairs invert the high level for the low pin.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      high_side_output <= '0;
      low_side_output <= '0;
      high_side_oe <= '0;
      low_side_oe <= '0;
    end else begin
      high_side_output <= duty_level;
      low_side_output <= (indep_sel & low_level) | (~indep_sel & ~duty_level);
      high_side_oe <= high_en;
      low_side_oe <= low_en;
    end
  end

endmodule

/* verilog/mpwm_time_base.sv */
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "mpwm_defines.svh"

// Overview of operation
// - Six-output unit has three duty pairs
// - Two-output unit has one duty pair
// - Complementary pair: low is inverted high
// - Idle-halt bit stops counting in idle
// - Postscale divides period events by field+1
// - Prescale gives 1, 4, 16, 64 cycles
// - Modes 10/11 up/down; 11 interrupts twice
// - Count bit 15 shows direction, read-only
// - Count value is writable 15-bit field
// - Period is 15 bits; bit 15 zero
// - Trigger when compare equals count
// - Trigger needs direction bit to match
// - High pin enables, reset to strap value
// - Low pin enables, zero releases pin
// - Pin enable reset follows configuration strap
module mpwm_time_base
  import mpwm_pkg::*;
#(
  parameter int NPAIR = 3,
  parameter int CW = 15
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic cpu_idle,
  input wire logic pin_strap,
  input wire logic [NPAIR-1:0] duty_level,
  input wire logic [NPAIR-1:0] low_level,
  output logic [NPAIR-1:0] high_side_output,
  output logic [NPAIR-1:0] low_side_output,
  output logic [NPAIR-1:0] high_side_oe,
  output logic [NPAIR-1:0] low_side_oe,
  output logic period_event,
  output logic special_trigger,
  output logic [CW-1:0] count_out,
  output logic count_direction
);

  // Control fields.
  logic time_base_on_r;
  logic idle_halt_select_r;
  logic [3:0] output_postscale_sel_r;
  logic [1:0] input_prescale_sel_r;
  mpwm_mode_t count_mode_sel_r;
  logic [CW-1:0] time_base_count_value_r;
  logic count_direction_r;
  logic [CW-1:0] period_value_r;
  logic trigger_direction_r;
  logic [CW-1:0] trigger_compare_value_r;
  logic [NPAIR-1:0] indep_sel_r;
  logic [NPAIR-1:0] high_pin_enable_r;
  logic [NPAIR-1:0] low_pin_enable_r;
  logic strap_done_r;
  logic [6:0] pre_cnt_r;
  logic [3:0] post_cnt_r;
  logic period_event_r;
  logic special_trigger_r;
  logic [6:0] pre_lim;
  logic tick;
  logic run;
  logic at_top;
  logic at_bottom;
  logic base_event;
  logic [CW-1:0] count_nxt;
  logic dir_nxt;
  logic stop_nxt;

  // Prescale ratio decode, kept as a function for reuse and clarity.
  function automatic logic [6:0] pre_limit(input logic [1:0] sel);
    case (sel)
      2'h0: pre_limit = `MPWM_PRE_DIV1;
      2'h1: pre_limit = `MPWM_PRE_DIV4;
      2'h2: pre_limit = `MPWM_PRE_DIV16;
      default: pre_limit = `MPWM_PRE_DIV64;
    endcase
  endfunction

  // Up/down test used for both count decode and event decode.
  function automatic logic is_updn(input mpwm_mode_t m);
    is_updn = (m == MPWM_MODE_UPDN) || (m == MPWM_MODE_UPDN_DBL);
  endfunction

  // The idle input comes from the core on this clock, so it needs no synchroniser.
  assign run = time_base_on_r && !(idle_halt_select_r && cpu_idle);
  assign pre_lim = pre_limit(input_prescale_sel_r);
  assign tick = run && (pre_cnt_r == pre_lim);
  assign at_top = (time_base_count_value_r >= period_value_r);
  assign at_bottom = (time_base_count_value_r == '0);

  // Prescaler: counts instruction cycles between time base advances.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt_r <= '0;
    end else if (!run || tick) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 7'h01;
    end
  end

  // Next count, direction and raw period event per mode.
  always_comb begin
    count_nxt = time_base_count_value_r;
    dir_nxt = count_direction_r;
    stop_nxt = 1'b0;
    base_event = 1'b0;
    if (tick) begin
      if (is_updn(count_mode_sel_r)) begin
        if (!count_direction_r) begin
          if (at_top) begin
            dir_nxt = 1'b1;
            count_nxt = time_base_count_value_r - 1'b1;
          end else begin
            // The top event fires on arrival at the period, as the bottom one does
            // at zero, so the two half-period updates stay evenly spaced.
            count_nxt = time_base_count_value_r + 1'b1;
            base_event = (count_mode_sel_r == MPWM_MODE_UPDN_DBL) &&
              (count_nxt >= period_value_r);
          end
        end else begin
          if (time_base_count_value_r <= 15'h0001) begin
            dir_nxt = 1'b0;
            count_nxt = '0;
            base_event = 1'b1;
          end else begin
            count_nxt = time_base_count_value_r - 1'b1;
          end
        end
      end else if (at_top) begin
        count_nxt = '0;
        base_event = 1'b1;
        stop_nxt = (count_mode_sel_r == MPWM_MODE_SINGLE);
      end else begin
        count_nxt = time_base_count_value_r + 1'b1;
      end
    end
  end

  // Count and direction; software writes the value, never the direction.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      time_base_count_value_r <= '0;
      count_direction_r <= 1'b0;
    end else if (reg_wr && reg_addr == `MPWM_ADDR_COUNT) begin
      time_base_count_value_r <= reg_wdata[`MPWM_VAL_HI:0];
    end else begin
      time_base_count_value_r <= count_nxt;
      count_direction_r <= dir_nxt;
    end
  end

  // Control register; single-event mode clears the on bit after one period.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      time_base_on_r <= 1'b0;
      idle_halt_select_r <= 1'b0;
      output_postscale_sel_r <= '0;
      input_prescale_sel_r <= '0;
      count_mode_sel_r <= MPWM_MODE_FREE;
    end else if (reg_wr && reg_addr == `MPWM_ADDR_TBCON) begin
      time_base_on_r <= reg_wdata[`MPWM_TB_ON_BIT];
      idle_halt_select_r <= reg_wdata[`MPWM_TB_IDLE_BIT];
      output_postscale_sel_r <= reg_wdata[`MPWM_TB_POST_HI:`MPWM_TB_POST_LO];
      input_prescale_sel_r <= reg_wdata[`MPWM_TB_PRE_HI:`MPWM_TB_PRE_LO];
      count_mode_sel_r <= mpwm_mode_t'(reg_wdata[`MPWM_TB_MODE_HI:`MPWM_TB_MODE_LO]);
    end else if (stop_nxt) begin
      time_base_on_r <= 1'b0;
    end
  end

  // Period and special event compare registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      period_value_r <= '0;
      trigger_direction_r <= 1'b0;
      trigger_compare_value_r <= '0;
    end else if (reg_wr) begin
      if (reg_addr == `MPWM_ADDR_PERIOD) begin
        period_value_r <= reg_wdata[`MPWM_VAL_HI:0];
      end
      if (reg_addr == `MPWM_ADDR_SECMP) begin
        trigger_direction_r <= reg_wdata[`MPWM_DIR_BIT];
        trigger_compare_value_r <= reg_wdata[`MPWM_VAL_HI:0];
      end
    end
  end

  // Pair configuration. The pin enable reset value is a strap, which an
  // asynchronous reset cannot load, so it is applied on the first clock after release.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      indep_sel_r <= '0;
      high_pin_enable_r <= '0;
      low_pin_enable_r <= '0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      high_pin_enable_r <= {NPAIR{pin_strap}};
      low_pin_enable_r <= {NPAIR{pin_strap}};
    end else if (reg_wr && reg_addr == `MPWM_ADDR_PAIRCFG) begin
      indep_sel_r <= reg_wdata[`MPWM_PMOD_LO +: NPAIR];
      high_pin_enable_r <= reg_wdata[`MPWM_PENH_LO +: NPAIR];
      low_pin_enable_r <= reg_wdata[`MPWM_PENL_LO +: NPAIR];
    end
  end

  // Postscaler: one output pulse every field+1 raw period events.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      post_cnt_r <= '0;
      period_event_r <= 1'b0;
    end else begin
      period_event_r <= 1'b0;
      if (base_event) begin
        if (post_cnt_r >= output_postscale_sel_r) begin
          post_cnt_r <= '0;
          period_event_r <= 1'b1;
        end else begin
          post_cnt_r <= post_cnt_r + 4'h1;
        end
      end
    end
  end

  // Special event: value match and direction match, one pulse per arrival.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      special_trigger_r <= 1'b0;
    end else begin
      special_trigger_r <= tick &&
        (count_nxt == trigger_compare_value_r) &&
        (dir_nxt == trigger_direction_r);
    end
  end

  assign period_event = period_event_r;
  assign special_trigger = special_trigger_r;
  assign count_out = time_base_count_value_r;
  assign count_direction = count_direction_r;

  // Read data valid in the cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `MPWM_ADDR_TBCON: reg_rdata <= {time_base_on_r, 1'b0, idle_halt_select_r, 5'h00,
          output_postscale_sel_r, input_prescale_sel_r, count_mode_sel_r};
        `MPWM_ADDR_COUNT: reg_rdata <= {count_direction_r, time_base_count_value_r};
        `MPWM_ADDR_PERIOD: reg_rdata <= {1'b0, period_value_r};
        `MPWM_ADDR_SECMP: reg_rdata <= {trigger_direction_r, trigger_compare_value_r};
        `MPWM_ADDR_PAIRCFG: reg_rdata <= 16'(({indep_sel_r} << `MPWM_PMOD_LO) |
          ({high_pin_enable_r} << `MPWM_PENH_LO) | {low_pin_enable_r});
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Pair outputs; NPAIR=3 gives the six-output unit, NPAIR=1 the two-output unit.
  mpwm_pair_out #(.NPAIR(NPAIR)) u_pairs (
    .clk(clk),
    .nrst(nrst),
    .duty_level(duty_level),
    .low_level(low_level),
    .indep_sel(indep_sel_r),
    .high_en(high_pin_enable_r),
    .low_en(low_pin_enable_r),
    .high_side_output(high_side_output),
    .low_side_output(low_side_output),
    .high_side_oe(high_side_oe),
    .low_side_oe(low_side_oe)
  );

endmodule

/* verif/mpwm_asserts.sv */
`timescale 1ns/1ns
// Watches the time base ports; helpers mirror the software-written registers.
module mpwm_asserts #(
  parameter int NPAIR = 3,
  parameter int CW = 15
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic cpu_idle,
  input wire logic [NPAIR-1:0] duty_level,
  input wire logic [NPAIR-1:0] low_level,
  input wire logic [NPAIR-1:0] high_side_output,
  input wire logic [NPAIR-1:0] low_side_output,
  input wire logic [NPAIR-1:0] high_side_oe,
  input wire logic [NPAIR-1:0] low_side_oe,
  input wire logic special_trigger,
  input wire logic [CW-1:0] count_out,
  input wire logic count_direction
);
  logic [15:0] ctl_r;
  logic [15:0] cmp_r;
  logic [15:0] pcfg_r;
  // Shadow copies; the on bit is not cleared on a single shot, which only weakens a_halted.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_r <= 16'h0;
      cmp_r <= 16'h0;
      pcfg_r <= 16'h0;
    end else if (reg_wr) begin
      if (reg_addr == 3'h0) ctl_r <= reg_wdata;
      if (reg_addr == 3'h3) cmp_r <= reg_wdata;
      if (reg_addr == 3'h4) pcfg_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rd_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0) else $error("stray read data");
  a_period_msb: assert property (reg_rd && reg_addr == 3'h2 |=> !reg_rdata[15])
    else $error("period bit 15 set");
  a_dir_read: assert property (reg_rd && reg_addr == 3'h1 |=>
    reg_rdata[15] == $past(count_direction))
    else $error("direction readback wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 3'h4 |=> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  // Pin checks start from a clocked edge, since the first edge after release still shows reset.
  a_high_copy: assert property (nrst |=> high_side_output == $past(duty_level))
    else $error("high side not duty level");
  a_comp_low: assert property (nrst |=>
    ((low_side_output ^ ~$past(duty_level)) & ~$past(pcfg_r[8 +: NPAIR])) == '0)
    else $error("complementary low wrong");
  a_indep_low: assert property (nrst |=>
    ((low_side_output ^ $past(low_level)) & $past(pcfg_r[8 +: NPAIR])) == '0)
    else $error("independent low wrong");
  a_oe_write: assert property (reg_wr && reg_addr == 3'h4 |=> ##1
    {high_side_oe, low_side_oe} == {pcfg_r[4 +: NPAIR], pcfg_r[0 +: NPAIR]})
    else $error("pin enables wrong");
  a_halted: assert property ((!ctl_r[15] || (ctl_r[13] && cpu_idle)) &&
    !(reg_wr && reg_addr == 3'h1) |=> $stable(count_out))
    else $error("count moved while halted");
  // The trigger is decoded from the new count against the compare value held before the edge;
  // a count write in that cycle overrides the value it was decoded from.
  a_trig_cause: assert property (special_trigger && !$past(reg_wr && reg_addr == 3'h1) |->
    count_out == $past(cmp_r[CW-1:0]) && count_direction == $past(cmp_r[15]))
    else $error("trigger without match");
endmodule

/* verif/mpwm_gate_drv.sv */
`timescale 1ns/1ns
// Gate driver of one bridge leg per pair; flags shoot-through when both switches are on.
module mpwm_gate_drv #(
  parameter int NPAIR = 3
) (
  input wire logic [NPAIR-1:0] hi,
  input wire logic [NPAIR-1:0] lo,
  input wire logic [NPAIR-1:0] hi_oe,
  input wire logic [NPAIR-1:0] lo_oe,
  output logic shoot
);
  assign shoot = |(hi & lo & hi_oe & lo_oe);
endmodule

/* verif/mpwm_time_base_test.sv */
`timescale 1ns/1ns
module mpwm_time_base_test;
  logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cpu_idle = 1'b1, pin_strap = 1'b1;
  logic [2:0] reg_addr = 3'h0, duty_level = 3'h0, low_level = 3'h5, hso, lso, hoe, loe;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, d, rdata2;
  logic pev, strig, cdir, shoot, hoe2, loe2;
  logic [14:0] cnt;
  logic [15:0] ctl [7] = '{16'h8000, 16'h8004, 16'h8008, 16'h800c, 16'h80f0, 16'h8002, 16'h8003};
  int gap [7] = '{4, 16, 64, 256, 64, 6, 3};
  int n_fail = 0, n_checks = 0, a, b, c;
  always #50 clk = ~clk;
  // Moving pin levels so every pair mapping is exercised each cycle; held in reset so
  // the levels seen at release are known.
  always @(posedge clk) begin
    if (nrst) begin
      duty_level <= duty_level + 3'h1;
      low_level <= ~low_level;
    end
  end
  mpwm_time_base #(.NPAIR(3), .CW(15)) mpwm_time_base_i (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_idle(cpu_idle), .pin_strap(pin_strap),
    .duty_level(duty_level), .low_level(low_level), .high_side_output(hso),
    .low_side_output(lso), .high_side_oe(hoe), .low_side_oe(loe), .period_event(pev),
    .special_trigger(strig), .count_out(cnt), .count_direction(cdir));
  mpwm_gate_drv #(.NPAIR(3)) mpwm_gate_drv_i (.hi(hso), .lo(lso), .hi_oe(hoe), .lo_oe(loe),
    .shoot(shoot));
  // Two-output unit on the same register port; only its pair configuration is checked.
  mpwm_time_base #(.NPAIR(1), .CW(15)) mpwm_time_base_i2 (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata2), .cpu_idle(cpu_idle), .pin_strap(pin_strap),
    .duty_level(duty_level[0]), .low_level(low_level[0]), .high_side_output(),
    .low_side_output(), .high_side_oe(hoe2), .low_side_oe(loe2), .period_event(),
    .special_trigger(), .count_out(), .count_direction());
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] ad, input logic [15:0] wd);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] ad, output logic [15:0] rv);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // Cycles from one period pulse to the next; the bound keeps a dead time base from hanging.
  task evgap(output int c);
    c = 0;
    while (pev !== 1'b1 && c < 600) begin
      @(posedge clk);
      #1 c++;
    end
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (pev !== 1'b1 && c < 600);
  endtask
  task cnt_ev(input int n, output int pe, output int tr, output int dn);
    pe = 0;
    tr = 0;
    dn = 0;
    repeat (n) begin
      @(posedge clk);
      #1 pe += (pev === 1'b1);
      tr += (strig === 1'b1);
      dn += (cdir === 1'b1);
    end
  endtask
  task stop_test;
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Both switches of one leg on at once would short the supply.
  always @(negedge clk) if (nrst && shoot !== 1'b0) chk({15'h0, shoot}, 16'h0);
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(3'h4, d);
    chk(d, 16'h0077);
    chk({10'h0, hoe, loe}, 16'h003f);
    chk(rdata2, 16'h0011);
    chk({14'h0, hoe2, loe2}, 16'h0003);
    wr(3'h4, 16'h0152);
    rd(3'h4, d);
    chk(d, 16'h0152);
    chk(rdata2, 16'h0110);
    chk({10'h0, hoe, loe}, 16'h002a);
    wr(3'h2, 16'hffff);
    rd(3'h2, d);
    chk(d, 16'h7fff);
    wr(3'h1, 16'h8005);
    rd(3'h1, d);
    chk(d, 16'h0005);
    rd(3'h6, d);
    chk(d, 16'h0000);
    wr(3'h2, 16'h0003);
    wr(3'h3, 16'h8002);
    // Idle is held high, so every case also shows counting on through idle.
    for (int i = 0; i < 7; i++) begin
      wr(3'h1, 16'h0000);
      wr(3'h0, ctl[i]);
      evgap(a);
      evgap(a);
      chk(a[15:0], gap[i][15:0]);
    end
    wr(3'h0, 16'h8002);
    cnt_ev(60, a, b, c);
    chk(b[15:0], 16'd10);
    chk(c[15:0], 16'd20);
    wr(3'h3, 16'h0002);
    cnt_ev(60, a, b, c);
    chk(b[15:0], 16'd10);
    wr(3'h0, 16'ha002);
    cnt_ev(40, a, b, c);
    chk(a[15:0], 16'd0);
    wr(3'h0, 16'h0002);
    cnt_ev(40, a, b, c);
    chk(a[15:0], 16'd0);
    wr(3'h1, 16'h0000);
    wr(3'h0, 16'h8001);
    repeat (20) @(posedge clk);
    rd(3'h0, d);
    chk(d, 16'h0001);
    chk({1'b0, cnt}, 16'h0000);
    // A second reset with the strap low must leave every pin released.
    @(posedge clk);
    nrst <= 1'b0;
    pin_strap <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(3'h4, d);
    chk(d, 16'h0000);
    chk({10'h0, hoe, loe}, 16'h0000);
    chk(rdata2, 16'h0000);
    stop_test;
  end
  // Watchdog well beyond the longest expected run.
  initial begin
    #2000000;
    n_fail++;
    stop_test;
  end
endmodule
bind mpwm_time_base mpwm_asserts #(.NPAIR(NPAIR), .CW(CW)) mpwm_asserts_i (.clk(clk),
  .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cpu_idle(cpu_idle), .duty_level(duty_level), .low_level(low_level),
  .high_side_output(high_side_output), .low_side_output(low_side_output),
  .high_side_oe(high_side_oe), .low_side_oe(low_side_oe), .special_trigger(special_trigger),
  .count_out(count_out), .count_direction(count_direction));
